// ===== core/step_cmd_input.sv
// Purpose: Command input decoding for a stepper drive
// Assumes: Isolated inputs already synchronous to ref_clk
// Notes: Step events are one-cycle pulses with a direction qualifier
//        clk_en low holds every flop, edge history included, so an edge on a line still high when clk_en returns is seen then
`timescale 1ns/10ps
`include "step_cmd_defines.svh"
module step_cmd_input #(
  parameter int PERIOD_CYC = `FLASH_PERIOD_CYC,
  parameter int ON_CYC = `FLASH_ON_CYC,
  parameter int SLOT_CYC = `FLASH_SLOT_CYC
) (
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Isolated command inputs
  input wire logic step_pulse,
  input wire logic dir_level,
  input wire logic drive_enable,
  input wire logic enable_connected,
  // Configuration
  input wire step_cmd_pkg::wiring_t wiring,
  input wire logic control_type_jumper,
  input wire logic microstep_jumper,
  // Protection status
  input wire step_cmd_pkg::fault_t faults,
  input wire logic power_good,
  // Motion outputs
  output logic step_out,
  output logic dir_cw,
  output logic enabled,
  output logic microstep_on,
  output logic dual_pulse_mode,
  // Indicators
  output logic red_led,
  output logic green_led
);
  import step_cmd_pkg::*;

  logic [1:0] line_in;
  wire logic [1:0] line_rise;
  logic step_rise;
  logic dir_rise;
  logic enable_level;

  // Bit 0 carries the step line, bit 1 the direction line
  assign line_in = {dir_level, step_pulse};
  assign step_rise = line_rise[0];
  assign dir_rise = line_rise[1];

  // Floating enable draws no current: treat as enabled
  // Sourcing drivers pull the line low to enable
  always_comb begin
    if (!enable_connected) begin
      enable_level = 1'b1;
    end else if (wiring == wiring_sinking) begin
      enable_level = drive_enable;
    end else begin
      enable_level = ~drive_enable;
    end
  end

  // ==========================================
  // Edge history, one detector each for the step and direction lines
  for (genvar g = 0; g < 2; g++) begin : g_edge
    logic prev_reg;

    // Reset to the idle level, so a line already high at release gives one step
    // Only an edge counts: a line held high must not repeat the step
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        prev_reg <= 1'b0;
      end else if (clk_en) begin
        prev_reg <= line_in[g];
      end
    end

    assign line_rise[g] = line_in[g] & ~prev_reg;
  end

  // ==========================================
  // Configuration and enable
  // Jumpers are static in use; registering them keeps outputs flop-driven
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      enabled <= 1'b1;
      dual_pulse_mode <= 1'b0;
      microstep_on <= 1'b1;
      green_led <= 1'b0;
    end else if (clk_en) begin
      enabled <= enable_level;
      dual_pulse_mode <= control_type_jumper;
      microstep_on <= ~microstep_jumper;
      green_led <= power_good;
    end
  end

  // ==========================================
  // Step generation
  // Direction is sampled at the step edge; setup is the controller's job
  // Limitation: both lines rising in one cycle in dual mode lose that step
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      step_out <= 1'b0;
      dir_cw <= 1'b1;
    end else if (clk_en) begin
      step_out <= 1'b0;
      if (enable_level) begin
        if (control_type_jumper) begin
          // Simultaneous edges cancel rather than pick a side
          if (step_rise && !dir_rise) begin
            step_out <= 1'b1;
            dir_cw <= 1'b1;
          end else if (dir_rise && !step_rise) begin
            step_out <= 1'b1;
            dir_cw <= 1'b0;
          end
        end else if (step_rise) begin
          step_out <= 1'b1;
          dir_cw <= dir_level;
        end
      end
    end
  end

  // ==========================================
  // Fault indicator
  // Timing counts are parameters so a bench can shorten the seconds-long period
  fault_flasher #(
    .PERIOD_CYC(PERIOD_CYC),
    .ON_CYC(ON_CYC),
    .SLOT_CYC(SLOT_CYC)
  ) u_flasher (
    .ref_clk(ref_clk),
    .rst(rst),
    .clk_en(clk_en),
    .faults(faults),
    .red_led(red_led)
  );

  // ==========================================
  // Checks
  // Each check looks one edge after the inputs that it names were sampled
  // Step checks use the combinational decode, the same one the step logic uses

  a_step_on_edge: assert property (@(posedge ref_clk) disable iff (rst)
      (clk_en && !control_type_jumper && enable_level && step_rise)
      |=> (step_out && dir_cw == $past(dir_level)))
    else $error("Rising step edge did not produce a step");

  a_step_only_edge: assert property (@(posedge ref_clk) disable iff (rst)
      (clk_en && !control_type_jumper && !step_rise) |=> !step_out)
    else $error("Step produced without a rising edge");

  a_step_disabled: assert property (@(posedge ref_clk) disable iff (rst)
      (clk_en && !enable_level) |=> !step_out)
    else $error("Step produced while disabled");

  a_step_cause: assert property (@(posedge ref_clk) disable iff (rst)
      $rose(step_out) |-> $past(clk_en && enable_level && (step_rise || dir_rise)))
    else $error("Step produced with no enabled edge behind it");

  a_dir_hold: assert property (@(posedge ref_clk) disable iff (rst)
      (clk_en && !step_rise && !dir_rise) |=> $stable(dir_cw))
    else $error("Direction changed without a step");

  a_enable_default: assert property (@(posedge ref_clk)
      $fell(rst) |-> enabled)
    else $error("Drive not enabled out of reset");

  a_enable_float: assert property (@(posedge ref_clk) disable iff (rst)
      (clk_en && !enable_connected) |=> enabled)
    else $error("Unconnected enable did not enable");

  a_enable_polarity: assert property (@(posedge ref_clk) disable iff (rst)
      (clk_en && enable_connected && wiring == wiring_sourcing)
      |=> (enabled == !$past(drive_enable)))
    else $error("Sourcing enable polarity wrong");

  a_enable_sinking: assert property (@(posedge ref_clk) disable iff (rst)
      (clk_en && enable_connected && wiring == wiring_sinking)
      |=> (enabled == $past(drive_enable)))
    else $error("Sinking enable polarity wrong");

  a_dual_cw: assert property (@(posedge ref_clk) disable iff (rst)
      (clk_en && control_type_jumper && enable_level && step_rise && !dir_rise)
      |=> (step_out && dir_cw))
    else $error("Dual pulse clockwise step missing");

  a_dual_ccw: assert property (@(posedge ref_clk) disable iff (rst)
      (clk_en && control_type_jumper && enable_level && dir_rise && !step_rise)
      |=> (step_out && !dir_cw))
    else $error("Dual pulse counter-clockwise step missing");

  a_dual_cancel: assert property (@(posedge ref_clk) disable iff (rst)
      (clk_en && control_type_jumper && step_rise == dir_rise) |=> !step_out)
    else $error("Dual pulse step without a single edge");

  a_jumper_decode: assert property (@(posedge ref_clk) disable iff (rst)
      clk_en |=> (microstep_on == !$past(microstep_jumper)))
    else $error("Microstep jumper decode wrong");

  a_mode_decode: assert property (@(posedge ref_clk) disable iff (rst)
      clk_en |=> (dual_pulse_mode == $past(control_type_jumper)))
    else $error("Control type jumper decode wrong");

  a_green_follow: assert property (@(posedge ref_clk) disable iff (rst)
      clk_en |=> (green_led == $past(power_good)))
    else $error("Power indicator does not follow power");

  a_reset_values: assert property (@(posedge ref_clk)
      rst |=> (!step_out && dir_cw && enabled && microstep_on && !dual_pulse_mode
      && !red_led && !green_led))
    else $error("Outputs not at reset values after reset");

  // Freeze checks keep a stalled clock enable from leaking a step downstream
  a_freeze_motion: assert property (@(posedge ref_clk) disable iff (rst)
      !clk_en |=> ($stable(step_out) && $stable(dir_cw)))
    else $error("Motion outputs moved while clock enable low");

  a_freeze_config: assert property (@(posedge ref_clk) disable iff (rst)
      !clk_en |=> ($stable(enabled) && $stable(dual_pulse_mode) && $stable(microstep_on)
      && $stable(green_led) && $stable(red_led)))
    else $error("Configuration outputs moved while clock enable low");
endmodule // step_cmd_input

// ===== core/step_cmd_defines.svh
// Purpose: Constants for the step/direction command input logic
// Assumes: 250 MHz ref_clk, inputs already synchronous
// Notes: Times are kept in ns, the period in us, and converted to cycle counts here
`ifndef STEP_CMD_DEFINES_SVH
`define STEP_CMD_DEFINES_SVH

`define CLK_PERIOD_NS 4
// Period in ns overflows a 32-bit int, so it is kept in us
`define FLASH_PERIOD_US 3000000
`define FLASH_PERIOD_CYC (`FLASH_PERIOD_US * (1000 / `CLK_PERIOD_NS))
`define FLASH_ON_NS 250000000
`define FLASH_ON_CYC (`FLASH_ON_NS / `CLK_PERIOD_NS)
`define FLASH_SLOT_NS 500000000
`define FLASH_SLOT_CYC (`FLASH_SLOT_NS / `CLK_PERIOD_NS)
`define FLASH_OVERCURRENT 3'h1
`define FLASH_OVERVOLTAGE 3'h2
`define FLASH_RESERVED 3'h3
`define FLASH_NO_MOTOR 3'h4

`endif

// ===== core/step_cmd_pkg.sv
// Purpose: Types for the step/direction command input logic
// Assumes: Nothing beyond the defines header
// Notes: Fault bit order follows flash-count priority
package step_cmd_pkg;
  typedef enum logic {
    wiring_sinking,
    wiring_sourcing
  } wiring_t;
  typedef enum logic [1:0] {
    flash_idle,
    flash_on,
    flash_off,
    flash_rest
  } flash_state_t;
  typedef struct packed {
    logic no_motor;
    logic reserved;
    logic over_voltage;
    logic over_current;
  } fault_t;
endpackage

// ===== core/fault_flasher.sv
// Purpose: Red fault indicator flash sequencer
// Assumes: Fault levels synchronous to ref_clk
// Notes: Count latched at period start, so a fault change never splits a burst
`timescale 1ns/10ps
`include "step_cmd_defines.svh"
module fault_flasher #(
  parameter int PERIOD_CYC = `FLASH_PERIOD_CYC,
  parameter int ON_CYC = `FLASH_ON_CYC,
  parameter int SLOT_CYC = `FLASH_SLOT_CYC
) (
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Fault levels
  input wire step_cmd_pkg::fault_t faults,
  // Indicator
  output logic red_led
);
  import step_cmd_pkg::*;

  flash_state_t state_reg;
  logic [31:0] period_reg;
  logic [31:0] slot_reg;
  logic [2:0] count_reg;
  logic [2:0] done_reg;
  logic [2:0] code;

  // Over-current wins, then voltage, reserved, missing motor
  always_comb begin
    if (faults.over_current) begin
      code = `FLASH_OVERCURRENT;
    end else if (faults.over_voltage) begin
      code = `FLASH_OVERVOLTAGE;
    end else if (faults.reserved) begin
      code = `FLASH_RESERVED;
    end else if (faults.no_motor) begin
      code = `FLASH_NO_MOTOR;
    end else begin
      code = 3'h0;
    end
  end

  // ==========================================
  // Sequencer
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg <= flash_idle;
      period_reg <= 32'h0;
      slot_reg <= 32'h0;
      count_reg <= 3'h0;
      done_reg <= 3'h0;
      red_led <= 1'b0;
    end else if (clk_en) begin
      case (state_reg)
        flash_idle: begin
          red_led <= 1'b0;
          if (code != 3'h0) begin
            count_reg <= code;
            done_reg <= 3'h0;
            period_reg <= 32'h0;
            slot_reg <= 32'h0;
            red_led <= 1'b1;
            state_reg <= flash_on;
          end
        end
        flash_on: begin
          period_reg <= period_reg + 32'h1;
          slot_reg <= slot_reg + 32'h1;
          if (slot_reg == 32'(ON_CYC - 1)) begin
            red_led <= 1'b0;
            done_reg <= done_reg + 3'h1;
            state_reg <= flash_off;
          end
        end
        flash_off: begin
          period_reg <= period_reg + 32'h1;
          slot_reg <= slot_reg + 32'h1;
          if (done_reg == count_reg) begin
            state_reg <= flash_rest;
          end else if (slot_reg == 32'(SLOT_CYC - 1)) begin
            slot_reg <= 32'h0;
            red_led <= 1'b1;
            state_reg <= flash_on;
          end
        end
        flash_rest: begin
          period_reg <= period_reg + 32'h1;
          if (period_reg >= 32'(PERIOD_CYC - 1)) begin
            // Relaunch here so bursts stay exactly one period apart
            if (code != 3'h0) begin
              count_reg <= code;
              done_reg <= 3'h0;
              period_reg <= 32'h0;
              slot_reg <= 32'h0;
              red_led <= 1'b1;
              state_reg <= flash_on;
            end else begin
              state_reg <= flash_idle;
            end
          end
        end
        default: begin
          state_reg <= flash_idle;
          red_led <= 1'b0;
        end
      endcase
    end
  end

  a_flash_no_fault: assert property (@(posedge ref_clk) disable iff (rst)
      (state_reg == flash_idle && code == 3'h0) |=> !red_led)
    else $error("Red indicator lit with no fault");
  a_flash_count_max: assert property (@(posedge ref_clk) disable iff (rst)
      done_reg <= 3'h4)
    else $error("More than four flashes in one period");
endmodule // fault_flasher

// ===== verification/step_source.sv
// Purpose: Pulse generator model that drives the step and direction lines
// Assumes: Bench raises go for one cycle; lines change on falling edges
// Notes: Keeps the controller's timing; a whole transfer takes 2*SETUP+2*PULSE cycles
`timescale 1ns/10ps
module step_source #(
  parameter int PULSE_CYC = 625,
  parameter int SETUP_CYC = 1250
) (
  // Clock
  input wire logic ref_clk,
  // Request from bench
  input wire logic go,
  input wire logic go_dir,
  input wire logic use_dir,
  // Lines to the drive, busy back to the bench
  output logic step_pulse,
  output logic dir_level,
  output logic busy
);
  initial begin
    step_pulse = 1'b0;
    dir_level = 1'b0;
    busy = 1'b0;
    forever begin
      @(posedge ref_clk);
      if (go) begin
        busy = 1'b1;
        // Give a freshly set enable time before direction moves
        repeat (SETUP_CYC) @(negedge ref_clk);
        // Dual pulse parks the direction line low so it gives no stray edge
        dir_level = use_dir ? 1'b0 : go_dir;
        repeat (SETUP_CYC) @(negedge ref_clk);
        if (use_dir) dir_level = 1'b1;
        else step_pulse = 1'b1;
        repeat (PULSE_CYC) @(negedge ref_clk);
        step_pulse = 1'b0;
        if (use_dir) dir_level = 1'b0;
        repeat (PULSE_CYC) @(negedge ref_clk);
        busy = 1'b0;
      end
    end
  end
endmodule // step_source

// ===== verification/testbench.sv
// Purpose: Self-checking bench for the command input logic
// Assumes: Short flash counts (40/2/4) stand in for the seconds-long ones
// Notes: Step timing comes from the source model at full length
`timescale 1ns/10ps
module testbench;
  import step_cmd_pkg::*;
  localparam int PERIOD = 40;
  logic ref_clk = 1'b0, rst, clk_en, drive_enable, enable_connected, power_good;
  logic control_type_jumper, microstep_jumper, go, go_dir, use_dir, d;
  logic step_pulse, dir_level, busy, step_out, dir_cw, enabled, microstep_on;
  logic dual_pulse_mode, red_led, green_led, red_prev, last_dir;
  wiring_t wiring;
  fault_t faults;
  int n_errors, n_compared, n_steps, n_flash, cyc;
  step_cmd_input #(.PERIOD_CYC(PERIOD), .ON_CYC(2), .SLOT_CYC(4)) dut (.ref_clk, .rst,
    .clk_en, .step_pulse, .dir_level, .drive_enable, .enable_connected, .wiring,
    .control_type_jumper, .microstep_jumper, .faults, .power_good, .step_out, .dir_cw,
    .enabled, .microstep_on, .dual_pulse_mode, .red_led, .green_led);
  step_source src (.ref_clk, .go, .go_dir, .use_dir, .step_pulse, .dir_level, .busy);
  // ==========================================
  // Clock, monitors, timeout
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (step_out === 1'b1) begin
      n_steps++;
      last_dir = dir_cw;
    end
    if (red_led === 1'b1 && red_prev !== 1'b1) n_flash++;
    red_prev = red_led;
    if (cyc == 80000) begin
      n_errors++;
      stop_test();
    end
  end
  // ==========================================
  // Helpers
  function automatic logic en_exp(logic c, wiring_t w, logic l);
    return !c ? 1'b1 : (w == wiring_sinking ? l : !l);
  endfunction
  function automatic int flash_exp(fault_t f);
    for (int b = 0; b < 4; b++) if (f[b]) return b + 1;
    return 0;
  endfunction
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic cfg(input logic c, input wiring_t w, input logic l, input logic ct);
    enable_connected = c;
    wiring = w;
    drive_enable = l;
    control_type_jumper = ct;
    @(negedge ref_clk);
  endtask
  task automatic do_step(input logic dv, input logic on_dir, input int n, input logic dx);
    n_steps = 0;
    go_dir = dv;
    use_dir = on_dir;
    go = 1'b1;
    @(negedge ref_clk);
    go = 1'b0;
    for (int i = 0; i < 4000 && busy; i++) @(negedge ref_clk);
    repeat (2) @(negedge ref_clk);
    check("step_count", n_steps, n);
    if (n > 0) check("dir_cw", last_dir, dx);
  endtask
  task automatic stop_test();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ==========================================
  // Main sequence
  initial begin
    {rst, clk_en, go, go_dir, use_dir, power_good, microstep_jumper} = 7'h60;
    {drive_enable, enable_connected, control_type_jumper, red_prev} = 4'h0;
    wiring = wiring_sinking;
    faults = '0;
    void'($urandom(32'hB8D46EDE));
    repeat (10) @(negedge ref_clk);
    check("reset_vals", {step_out, dir_cw, enabled, microstep_on}, 4'h7);
    check("reset_leds", {dual_pulse_mode, red_led, green_led}, 3'h0);
    rst = 1'b0;
    for (int i = 0; i < 16; i++) begin
      {microstep_jumper, power_good} = 2'($urandom_range(3));
      cfg(i[0], wiring_t'(i[1]), i[2], i[3]);
      check("enabled", enabled, en_exp(i[0], wiring_t'(i[1]), i[2]));
      check("dual_mode", dual_pulse_mode, i[3]);
      check("microstep", microstep_on, !microstep_jumper);
      check("green", green_led, power_good);
    end
    // Clock enable low must hold the last decoded settings
    clk_en = 1'b0;
    cfg(1'b0, wiring_sinking, 1'b0, 1'b0);
    check("frozen", {enabled, dual_pulse_mode}, 2'h1);
    clk_en = 1'b1;
    cfg(1'b0, wiring_sinking, 1'b0, 1'b0);
    repeat (4) begin
      d = 1'($urandom_range(1));
      do_step(d, 1'b0, 1, d);
    end
    // Disabled drive must swallow the edge
    cfg(1'b1, wiring_sinking, 1'b0, 1'b0);
    do_step(1'b1, 1'b0, 0, 1'b1);
    cfg(1'b1, wiring_sourcing, 1'b0, 1'b1);
    do_step(1'b0, 1'b0, 1, 1'b1);
    do_step(1'b0, 1'b1, 1, 1'b0);
    for (int k = 1; k <= 4; k++) begin
      faults = '0;
      n_flash = 0;
      repeat (50) @(negedge ref_clk);
      check("idle_flash", n_flash, 0);
      faults = fault_t'(4'(($urandom << k) | (1 << (k - 1))));
      n_flash = 0;
      repeat (PERIOD) @(negedge ref_clk);
      check("flashes", n_flash, flash_exp(faults));
    end
    stop_test();
  end
endmodule // testbench
